// ### sim/tcr_pins_model.sv
// pin-side partner: trigger pin, count pin and timer 1 overflow pulses
// assumes the bench requests pin changes just after rising edges
`timescale 1ns/1ps
`default_nettype none
module tcr_pins_model #(
    parameter int T1_PER = 10
) (
    input wire logic mclk,
    input wire logic trigLow,
    input wire logic cntGo,
    output logic triggerPin,
    output logic countInPin,
    output logic timer1Ovf
);
    int t1Cnt = 0;
    always @(posedge mclk) begin
        triggerPin <= !trigLow;
        countInPin <= !cntGo;
        t1Cnt <= (t1Cnt == T1_PER - 1) ? 0 : t1Cnt + 1;
        timer1Ovf <= (t1Cnt == T1_PER - 1);
    end
endmodule : tcr_pins_model
`default_nettype wire

// ### sim/tcr_timer2_tb.sv
// self-checking bench for the timer2 block over AXI4-Lite
// assumes tcr_pkg and the pin partner model are compiled first
`timescale 1ns/1ps
`default_nettype none
module tcr_timer2_tb;
    import tcr_pkg::*;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    tcr_axi_req_s req = '0;
    tcr_axi_rsp_s rsp;
    logic [1:0] serMode = 2'h0;
    logic [3:0] isrEnter = 4'h0;
    logic trigLow = 1'b0;
    logic cntGo = 1'b0;
    logic triggerPin, countInPin, timer1Ovf, rxBaudTick, txBaudTick, timerIrq, clockOutO, clockOutOe;
    logic [3:0] extIrqClr, acc;
    int miscompares = 0;
    int checksDone = 0;
    int gap;
    int expReg [int];
    logic [31:0] seed = 32'h0000005f;
    logic [31:0] rdat, lowA;
    logic [1:0] resp;
    logic [7:0] r8;
    tcr_timer2 u_dut (.mclk(mclk), .arst_n(arst_n), .axiReq(req), .axiRsp(rsp), .triggerPin(triggerPin),
        .countInPin(countInPin), .serMode(serMode), .timer1Ovf(timer1Ovf), .isrEnter(isrEnter),
        .rxBaudTick(rxBaudTick), .txBaudTick(txBaudTick), .timerIrq(timerIrq), .clockOutO(clockOutO),
        .clockOutOe(clockOutOe), .extIrqClr(extIrqClr));
    tcr_pins_model #(.T1_PER(10)) u_pins (.mclk(mclk), .trigLow(trigLow), .cntGo(cntGo),
        .triggerPin(triggerPin), .countInPin(countInPin), .timer1Ovf(timer1Ovf));
    initial begin
        forever #25 mclk = ~mclk;
    end
    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    function automatic logic pick(input int sel);
        return (sel == 0) ? rxBaudTick : (sel == 1) ? txBaudTick : clockOutO;
    endfunction : pick
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        checksDone++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t %s seen %h exp %h", $time, msg, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        logic a, w, ta, tw, tb;
        int n;
        @(posedge mclk);
        req.awvalid <= 1'b1;
        req.awaddr <= {idx, 2'b00};
        req.wvalid <= 1'b1;
        req.wdata <= {24'h0, d};
        req.wstrb <= 4'hf;
        req.bready <= 1'b1;
        a = 1'b1;
        w = 1'b1;
        tb = 1'b0;
        n = 0;
        while (a || w || !tb) begin
            @(negedge mclk);
            ta = rsp.awready;
            tw = rsp.wready;
            tb = rsp.bvalid;
            resp = rsp.bresp;
            @(posedge mclk);
            n++;
            if (a && ta) begin
                req.awvalid <= 1'b0;
                a = 1'b0;
            end
            if (w && tw) begin
                req.wvalid <= 1'b0;
                w = 1'b0;
            end
        end
        req.bready <= 1'b0;
        chk(n, 3, "write answer latency");
    endtask : wr
    task automatic rd(input logic [9:0] idx);
        logic a, tr;
        int n;
        @(posedge mclk);
        req.arvalid <= 1'b1;
        req.araddr <= {idx, 2'b00};
        req.rready <= 1'b1;
        a = 1'b1;
        tr = 1'b0;
        n = 0;
        while (!tr) begin
            @(negedge mclk);
            if (a && rsp.arready) begin
                a = 1'b0;
            end
            tr = rsp.rvalid;
            rdat = rsp.rdata;
            resp = rsp.rresp;
            @(posedge mclk);
            n++;
            if (!a) begin
                req.arvalid <= 1'b0;
            end
        end
        req.rready <= 1'b0;
        chk(n, 2, "read answer latency");
    endtask : rd
    task automatic rdc(input logic [9:0] idx, input logic [7:0] e);
        rd(idx);
        chk(rdat, {24'h0, e}, "register read");
    endtask : rdc
    task automatic pinFall(input logic isCount);
        @(posedge mclk);
        if (isCount) cntGo <= 1'b1;
        else trigLow <= 1'b1;
        repeat (6) @(posedge mclk);
        cntGo <= 1'b0;
        trigLow <= 1'b0;
        repeat (6) @(posedge mclk);
    endtask : pinFall
    task automatic gapOf(input int sel, output int g);
        int n, k;
        logic v, pv;
        k = 0;
        n = 0;
        g = -1;
        pv = pick(sel);
        while (k < 2 && n < 300) begin
            @(negedge mclk);
            v = pick(sel);
            n++;
            if ((sel == 2) ? (v !== pv) : (v === 1'b1 && pv !== 1'b1)) begin
                if (k == 1) g = n;
                k++;
                n = 0;
            end
            pv = v;
        end
    endtask : gapOf
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checksDone, miscompares);
        if (miscompares == 0 && checksDone > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        #(50 * 20000);
        miscompares++;
        tally_and_finish();
    end
    // ****************************************************************
    // scenarios
    // ****************************************************************
    initial begin
        repeat (8) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        for (int i = 'h0c8; i <= 'h0ce; i++) rdc(i[9:0], TCR_RST_BYTE);
        rd(10'h0cf);
        chk(resp, TCR_RESP_SLVERR, "unmapped read");
        chk(rdat, 32'h0, "unmapped read data");
        wr(10'h0cf, 8'h5a);
        chk(resp, TCR_RESP_SLVERR, "unmapped write");
        for (int i = 'h0c9; i <= 'h0cd; i++) begin
            lowA = xs();
            r8 = lowA[7:0];
            wr(i[9:0], r8);
            expReg[i] = (i == 'h0c9) ? (r8 & 8'hfb) : r8;
        end
        foreach (expReg[i]) rdc(i[9:0], expReg[i][7:0]);
        chk(clockOutOe, expReg['h0c9][1], "clock out enable");
        for (int t = 0; t < 2; t++) begin
            lowA = xs();
            r8 = lowA[7:0];
            wr(TCR_IDX_TIMER_MODE_CONTROL, {r8[7:4], 4'h0});
            @(posedge mclk);
            isrEnter <= 4'hf;
            @(posedge mclk);
            isrEnter <= 4'h0;
            acc = 4'h0;
            repeat (4) begin
                @(negedge mclk);
                acc = acc | extIrqClr;
            end
            chk(acc, r8[7:4], "autoclear pulses");
        end
        wr(TCR_IDX_TIMER_MODE_CONTROL, 8'h00);
        wr(TCR_IDX_COUNT_LOW, 8'hcd);
        wr(TCR_IDX_COUNT_HIGH, 8'hab);
        wr(TCR_IDX_TIMER_CONTROL, 8'h07);
        pinFall(1'b0);
        rdc(TCR_IDX_TIMER_CONTROL, 8'h07);
        rdc(TCR_IDX_CAPTURE_RELOAD_LOW, expReg['h0ca]);
        wr(TCR_IDX_TIMER_CONTROL, 8'h0f);
        pinFall(1'b0);
        rdc(TCR_IDX_TIMER_CONTROL, 8'h4f);
        chk(timerIrq, 1'b1, "edge irq");
        rdc(TCR_IDX_CAPTURE_RELOAD_LOW, 8'hcd);
        rdc(TCR_IDX_CAPTURE_RELOAD_HIGH, 8'hab);
        wr(TCR_IDX_TIMER_MODE_CONTROL, 8'h08);
        wr(TCR_IDX_COUNT_LOW, 8'h57);
        wr(TCR_IDX_COUNT_HIGH, 8'h13);
        pinFall(1'b0);
        rdc(TCR_IDX_CAPTURE_RELOAD_HIGH, 8'h13);
        rdc(TCR_IDX_COUNT_LOW, 8'h00);
        rdc(TCR_IDX_COUNT_HIGH, 8'h00);
        repeat (5) pinFall(1'b1);
        rdc(TCR_IDX_COUNT_LOW, 8'h05);
        wr(TCR_IDX_TIMER_CONTROL, 8'h00);
        rdc(TCR_IDX_TIMER_CONTROL, 8'h00);
        chk(timerIrq, 1'b0, "irq cleared");
        wr(TCR_IDX_TIMER_MODE_CONTROL, 8'h00);
        wr(TCR_IDX_TICK_CONTROL, 8'h01);
        wr(TCR_IDX_CAPTURE_RELOAD_LOW, 8'h00);
        wr(TCR_IDX_CAPTURE_RELOAD_HIGH, 8'h12);
        wr(TCR_IDX_COUNT_LOW, 8'hfe);
        wr(TCR_IDX_COUNT_HIGH, 8'hff);
        wr(TCR_IDX_TIMER_CONTROL, 8'h04);
        repeat (30) @(posedge mclk);
        rdc(TCR_IDX_TIMER_CONTROL, 8'h84);
        wr(TCR_IDX_TIMER_CONTROL, 8'h80);
        rdc(TCR_IDX_COUNT_HIGH, 8'h12);
        rd(TCR_IDX_COUNT_LOW);
        lowA = rdat;
        repeat (20) @(posedge mclk);
        rdc(TCR_IDX_COUNT_LOW, lowA[7:0]);
        wr(TCR_IDX_TIMER_CONTROL, 8'h08);
        pinFall(1'b0);
        rdc(TCR_IDX_TIMER_CONTROL, 8'h48);
        rdc(TCR_IDX_COUNT_LOW, 8'h00);
        wr(TCR_IDX_TIMER_CONTROL, 8'h00);
        wr(TCR_IDX_TIMER_MODE_CONTROL, 8'h01);
        wr(TCR_IDX_CAPTURE_RELOAD_LOW, 8'h03);
        wr(TCR_IDX_CAPTURE_RELOAD_HIGH, 8'h00);
        wr(TCR_IDX_COUNT_LOW, 8'h05);
        wr(TCR_IDX_COUNT_HIGH, 8'h00);
        @(posedge mclk);
        trigLow <= 1'b1;
        wr(TCR_IDX_TIMER_CONTROL, 8'h04);
        repeat (30) @(posedge mclk);
        rdc(TCR_IDX_TIMER_CONTROL, 8'hc4);
        rdc(TCR_IDX_COUNT_HIGH, 8'hff);
        trigLow <= 1'b0;
        wr(TCR_IDX_TIMER_CONTROL, 8'h00);
        wr(TCR_IDX_TIMER_MODE_CONTROL, 8'h02);
        wr(TCR_IDX_CAPTURE_RELOAD_LOW, 8'hf0);
        wr(TCR_IDX_CAPTURE_RELOAD_HIGH, 8'hff);
        wr(TCR_IDX_COUNT_LOW, 8'hf0);
        wr(TCR_IDX_COUNT_HIGH, 8'hff);
        serMode <= 2'h1;
        wr(TCR_IDX_TIMER_CONTROL, 8'h25);
        gapOf(0, gap);
        chk(gap, TCR_DIV_BAUD * 16, "rx baud gap");
        gapOf(1, gap);
        chk(gap, 10, "tx from timer1");
        gapOf(2, gap);
        chk(gap, TCR_DIV_BAUD * 16, "clock out gap");
        rdc(TCR_IDX_TIMER_CONTROL, 8'h25);
        wr(TCR_IDX_TIMER_CONTROL, 8'h35);
        gapOf(1, gap);
        chk(gap, TCR_DIV_BAUD * 16, "tx baud gap");
        tally_and_finish();
    end
endmodule : tcr_timer2_tb
`default_nettype wire

// ### verilog/tcr_pkg.sv
// timer2 capture/reload/baud package: register indices, fields, divider counts, bus carriers
// assumes an AXI4-Lite master with 32-bit data and 12-bit byte addresses
package tcr_pkg;
    // ****************************************************************
    // register indices (byte address is four times the index)
    // ****************************************************************
    localparam logic [9:0] TCR_IDX_TIMER_CONTROL = 10'h0c8;
    localparam logic [9:0] TCR_IDX_TIMER_MODE_CONTROL = 10'h0c9;
    localparam logic [9:0] TCR_IDX_CAPTURE_RELOAD_LOW = 10'h0ca;
    localparam logic [9:0] TCR_IDX_CAPTURE_RELOAD_HIGH = 10'h0cb;
    localparam logic [9:0] TCR_IDX_COUNT_LOW = 10'h0cc;
    localparam logic [9:0] TCR_IDX_COUNT_HIGH = 10'h0cd;
    localparam logic [9:0] TCR_IDX_TICK_CONTROL = 10'h0ce;
    // ****************************************************************
    // timer_control fields
    // ****************************************************************
    localparam int TCR_CTL_OVERFLOW_FLAG = 7;
    localparam int TCR_CTL_EXTERNAL_EDGE_FLAG = 6;
    localparam int TCR_CTL_RX_BAUD_SEL = 5;
    localparam int TCR_CTL_TX_BAUD_SEL = 4;
    localparam int TCR_CTL_EDGE_ENABLE = 3;
    localparam int TCR_CTL_RUN_CONTROL = 2;
    localparam int TCR_CTL_COUNT_SOURCE_SELECT = 1;
    localparam int TCR_CTL_CAPTURE_RELOAD_SELECT = 0;
    // ****************************************************************
    // timer_mode_control fields, then the tick control rate select bit
    // ****************************************************************
    localparam int TCR_MOD_EXT_IRQ_AUTOCLEAR_LSB = 4;
    localparam int TCR_MOD_CAPTURE_AUTO_CLEAR = 3;
    localparam int TCR_MOD_CLOCK_OUT_ENABLE = 1;
    localparam int TCR_MOD_DOWN_COUNT_ENABLE = 0;
    localparam int TCR_TICK_RATE_SELECT = 0;
    // ****************************************************************
    // reset values, overflow value, tick dividers and bus response codes
    // ****************************************************************
    localparam logic [7:0] TCR_RST_BYTE = 8'h00;
    localparam logic [15:0] TCR_RST_WORD = 16'h0000;
    localparam logic [15:0] TCR_ALL_ONES = 16'hffff;
    localparam logic [3:0] TCR_DIV_SLOW = 4'hc;
    localparam logic [3:0] TCR_DIV_FAST = 4'h4;
    localparam logic [3:0] TCR_DIV_BAUD = 4'h2;
    localparam logic [1:0] TCR_RESP_OKAY = 2'h0;
    localparam logic [1:0] TCR_RESP_SLVERR = 2'h2;
    // ****************************************************************
    // bus carriers
    // ****************************************************************
    typedef struct packed {
        logic awvalid;
        logic [11:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [11:0] araddr;
        logic rready;
    } tcr_axi_req_s;
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } tcr_axi_rsp_s;
endpackage : tcr_pkg

// ### verilog/tcr_timer2.sv
// 16-bit timer with capture, auto-reload, up/down count, baud tick and clock out
// assumes one 20 MHz clock mclk; pins are asynchronous; serial mode and timer 1 overflow are synchronous
`timescale 1ns/1ps
`default_nettype none
module tcr_timer2 (
    input wire logic mclk,
    input wire logic arst_n,
    input wire tcr_pkg::tcr_axi_req_s axiReq,
    output tcr_pkg::tcr_axi_rsp_s axiRsp,
    input wire logic triggerPin,
    input wire logic countInPin,
    input wire logic [1:0] serMode,
    input wire logic timer1Ovf,
    input wire logic [3:0] isrEnter,
    output logic rxBaudTick,
    output logic txBaudTick,
    output logic timerIrq,
    output logic clockOutO,
    output logic clockOutOe,
    output logic [3:0] extIrqClr
);
    import tcr_pkg::*;

    typedef struct packed {
        tcr_axi_rsp_s rsp;
        logic awPend;
        logic [9:0] awIdx;
        logic wPend;
        logic [7:0] wData;
        logic wLane;
        logic [7:0] ctrl;
        logic [7:0] mode;
        logic [7:0] tickCtl;
        logic [15:0] rcap;
        logic [15:0] cnt;
        logic [2:0] trigSync;
        logic [2:0] cntSync;
        logic [3:0] divCnt;
        logic rxBaud;
        logic txBaud;
        logic irq;
        logic clkOut;
        logic clkOe;
        logic [3:0] extClr;
    } tcr_state_s;

    tcr_state_s s_q;
    tcr_state_s s_d;
    logic [1:0] rstSync_q;
    logic rstSyncN;
    logic baud;
    logic downMode;
    logic tick;
    logic tickInt;
    logic ovf;
    logic edgeHit;
    logic doWr;
    logic setTf;
    logic setExf;
    logic exfTog;
    logic wrHit;
    logic [3:0] divLimit;
    logic [7:0] rdByte;

    // ****************************************************************
    // reset release
    // ****************************************************************
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rstSync_q <= 2'h0;
        end else begin
            rstSync_q <= {rstSync_q[0], 1'b1};
        end
    end
    assign rstSyncN = rstSync_q[1];

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        s_d = s_q;
        ovf = 1'b0;
        setTf = 1'b0;
        setExf = 1'b0;
        exfTog = 1'b0;
        wrHit = 1'b1;
        rdByte = TCR_RST_BYTE;
        // pin synchronisers
        s_d.trigSync = {s_q.trigSync[1:0], triggerPin};
        s_d.cntSync = {s_q.cntSync[1:0], countInPin};
        baud = s_q.ctrl[TCR_CTL_RX_BAUD_SEL] | s_q.ctrl[TCR_CTL_TX_BAUD_SEL];
        // direction control only in plain auto-reload
        downMode = !baud && !s_q.ctrl[TCR_CTL_CAPTURE_RELOAD_SELECT] && s_q.mode[TCR_MOD_DOWN_COUNT_ENABLE];
        // tick divider, two clocks in baud mode
        if (baud) begin
            divLimit = TCR_DIV_BAUD - 4'h1;
        end else if (s_q.tickCtl[TCR_TICK_RATE_SELECT]) begin
            divLimit = TCR_DIV_FAST - 4'h1;
        end else begin
            divLimit = TCR_DIV_SLOW - 4'h1;
        end
        tickInt = s_q.divCnt >= divLimit;
        s_d.divCnt = tickInt ? 4'h0 : s_q.divCnt + 4'h1;
        if (!s_q.ctrl[TCR_CTL_RUN_CONTROL]) begin
            tick = 1'b0;
        end else if (baud || !s_q.ctrl[TCR_CTL_COUNT_SOURCE_SELECT]) begin
            tick = tickInt;
        end else begin
            tick = s_q.cntSync[2] && !s_q.cntSync[1];
        end
        // ************************************************************
        // counter
        // ************************************************************
        if (tick) begin
            if (downMode && !s_q.trigSync[1]) begin
                if (s_q.cnt == s_q.rcap) begin
                    s_d.cnt = TCR_ALL_ONES;
                    ovf = 1'b1;
                    exfTog = 1'b1;
                end else begin
                    s_d.cnt = s_q.cnt - 16'h0001;
                end
            end else if (s_q.cnt == TCR_ALL_ONES) begin
                ovf = 1'b1;
                exfTog = downMode;
                s_d.cnt = (baud || !s_q.ctrl[TCR_CTL_CAPTURE_RELOAD_SELECT]) ? s_q.rcap : TCR_RST_WORD;
            end else begin
                s_d.cnt = s_q.cnt + 16'h0001;
            end
        end
        // overflow flag only outside baud mode
        setTf = ovf && !baud;
        // trigger edge gated by enable and baud mode
        edgeHit = s_q.trigSync[2] && !s_q.trigSync[1] && s_q.ctrl[TCR_CTL_EDGE_ENABLE] && !baud;
        if (edgeHit) begin
            if (s_q.ctrl[TCR_CTL_CAPTURE_RELOAD_SELECT]) begin
                s_d.rcap = s_q.cnt;
                setExf = 1'b1;
                if (s_q.mode[TCR_MOD_CAPTURE_AUTO_CLEAR]) begin
                    s_d.cnt = TCR_RST_WORD;
                end
            end else if (!s_q.mode[TCR_MOD_DOWN_COUNT_ENABLE]) begin
                s_d.cnt = s_q.rcap;
                setExf = 1'b1;
            end
        end
        // ************************************************************
        // bus write
        // ************************************************************
        if (axiReq.awvalid && s_q.rsp.awready) begin
            s_d.awPend = 1'b1;
            s_d.awIdx = axiReq.awaddr[11:2];
        end
        if (axiReq.wvalid && s_q.rsp.wready) begin
            s_d.wPend = 1'b1;
            s_d.wData = axiReq.wdata[7:0];
            s_d.wLane = axiReq.wstrb[0];
        end
        if (s_q.rsp.bvalid && axiReq.bready) begin
            s_d.rsp.bvalid = 1'b0;
        end
        doWr = s_q.awPend && s_q.wPend && !s_q.rsp.bvalid;
        if (doWr) begin
            s_d.awPend = 1'b0;
            s_d.wPend = 1'b0;
            s_d.rsp.bvalid = 1'b1;
            if (s_q.awIdx == TCR_IDX_TIMER_CONTROL) begin
                if (s_q.wLane) s_d.ctrl = s_q.wData;
            end else if (s_q.awIdx == TCR_IDX_TIMER_MODE_CONTROL) begin
                if (s_q.wLane) s_d.mode = s_q.wData & 8'hfb;
            end else if (s_q.awIdx == TCR_IDX_CAPTURE_RELOAD_LOW) begin
                if (s_q.wLane) s_d.rcap[7:0] = s_q.wData;
            end else if (s_q.awIdx == TCR_IDX_CAPTURE_RELOAD_HIGH) begin
                if (s_q.wLane) s_d.rcap[15:8] = s_q.wData;
            end else if (s_q.awIdx == TCR_IDX_COUNT_LOW) begin
                if (s_q.wLane) s_d.cnt[7:0] = s_q.wData;
            end else if (s_q.awIdx == TCR_IDX_COUNT_HIGH) begin
                if (s_q.wLane) s_d.cnt[15:8] = s_q.wData;
            end else if (s_q.awIdx == TCR_IDX_TICK_CONTROL) begin
                if (s_q.wLane) s_d.tickCtl = s_q.wData & 8'h01;
            end else begin
                wrHit = 1'b0;
            end
            s_d.rsp.bresp = wrHit ? TCR_RESP_OKAY : TCR_RESP_SLVERR;
        end
        // hardware set wins over software clear
        s_d.ctrl[TCR_CTL_OVERFLOW_FLAG] = s_d.ctrl[TCR_CTL_OVERFLOW_FLAG] | setTf;
        s_d.ctrl[TCR_CTL_EXTERNAL_EDGE_FLAG] = (s_d.ctrl[TCR_CTL_EXTERNAL_EDGE_FLAG] | setExf) ^ exfTog;
        s_d.rsp.awready = !s_d.awPend && !s_d.rsp.bvalid;
        s_d.rsp.wready = !s_d.wPend && !s_d.rsp.bvalid;
        // ************************************************************
        // bus read
        // ************************************************************
        if (s_q.rsp.rvalid && axiReq.rready) begin
            s_d.rsp.rvalid = 1'b0;
        end
        if (axiReq.arvalid && s_q.rsp.arready) begin
            s_d.rsp.rvalid = 1'b1;
            s_d.rsp.rresp = TCR_RESP_OKAY;
            if (axiReq.araddr[11:2] == TCR_IDX_TIMER_CONTROL) begin
                rdByte = s_q.ctrl;
            end else if (axiReq.araddr[11:2] == TCR_IDX_TIMER_MODE_CONTROL) begin
                rdByte = s_q.mode;
            end else if (axiReq.araddr[11:2] == TCR_IDX_CAPTURE_RELOAD_LOW) begin
                rdByte = s_q.rcap[7:0];
            end else if (axiReq.araddr[11:2] == TCR_IDX_CAPTURE_RELOAD_HIGH) begin
                rdByte = s_q.rcap[15:8];
            end else if (axiReq.araddr[11:2] == TCR_IDX_COUNT_LOW) begin
                rdByte = s_q.cnt[7:0];
            end else if (axiReq.araddr[11:2] == TCR_IDX_COUNT_HIGH) begin
                rdByte = s_q.cnt[15:8];
            end else if (axiReq.araddr[11:2] == TCR_IDX_TICK_CONTROL) begin
                rdByte = s_q.tickCtl;
            end else begin
                s_d.rsp.rresp = TCR_RESP_SLVERR;
            end
            s_d.rsp.rdata = {24'h000000, rdByte};
        end
        s_d.rsp.arready = !s_d.rsp.rvalid;
        // ************************************************************
        // side outputs
        // ************************************************************
        // receive baud source in modes 1 and 3
        s_d.rxBaud = serMode[0] && (s_q.ctrl[TCR_CTL_RX_BAUD_SEL] ? ovf : timer1Ovf);
        // transmit baud source in modes 1 and 3
        s_d.txBaud = serMode[0] && (s_q.ctrl[TCR_CTL_TX_BAUD_SEL] ? ovf : timer1Ovf);
        s_d.irq = s_d.ctrl[TCR_CTL_OVERFLOW_FLAG] | s_d.ctrl[TCR_CTL_EXTERNAL_EDGE_FLAG];
        // clock out toggles on overflow when enabled
        if (s_q.mode[TCR_MOD_CLOCK_OUT_ENABLE] && ovf) begin
            s_d.clkOut = !s_q.clkOut;
        end
        s_d.clkOe = s_d.mode[TCR_MOD_CLOCK_OUT_ENABLE];
        s_d.extClr = s_q.mode[7:TCR_MOD_EXT_IRQ_AUTOCLEAR_LSB] & isrEnter;
    end

    always_ff @(posedge mclk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign axiRsp = s_q.rsp;
    assign rxBaudTick = s_q.rxBaud;
    assign txBaudTick = s_q.txBaud;
    assign timerIrq = s_q.irq;
    assign clockOutO = s_q.clkOut;
    assign clockOutOe = s_q.clkOe;
    assign extIrqClr = s_q.extClr;

    // ****************************************************************
    // checks
    // ****************************************************************
    a_overflow_flag: assert property (@(posedge mclk) disable iff (!rstSyncN)
        (ovf && !baud) |=> s_q.ctrl[TCR_CTL_OVERFLOW_FLAG]) else $error("overflow flag not set");
    a_flag_baud_block: assert property (@(posedge mclk) disable iff (!rstSyncN)
        (baud && !doWr && !s_q.ctrl[TCR_CTL_OVERFLOW_FLAG]) |=> !s_q.ctrl[TCR_CTL_OVERFLOW_FLAG])
        else $error("overflow flag set in baud mode");
    a_baud_reload: assert property (@(posedge mclk) disable iff (!rstSyncN)
        (ovf && baud && !doWr) |=> s_q.cnt == $past(s_q.rcap)) else $error("baud reload missed");
    a_run_hold: assert property (@(posedge mclk) disable iff (!rstSyncN)
        (!s_q.ctrl[TCR_CTL_RUN_CONTROL] && !doWr && !edgeHit) |=> $stable(s_q.cnt))
        else $error("count moved while stopped");
    a_baud_rate: assert property (@(posedge mclk) disable iff (!rstSyncN)
        (baud && tick && $stable(s_q.ctrl)) |=> !tick) else $error("baud tick too fast");
    a_capture_copy: assert property (@(posedge mclk) disable iff (!rstSyncN)
        (edgeHit && s_q.ctrl[TCR_CTL_CAPTURE_RELOAD_SELECT] && !doWr) |=> s_q.rcap == $past(s_q.cnt))
        else $error("capture missed");
    a_capture_clear: assert property (@(posedge mclk) disable iff (!rstSyncN)
        (edgeHit && s_q.ctrl[TCR_CTL_CAPTURE_RELOAD_SELECT] && s_q.mode[TCR_MOD_CAPTURE_AUTO_CLEAR] && !doWr)
        |=> s_q.cnt == TCR_RST_WORD) else $error("auto clear missed");
    a_edge_reload: assert property (@(posedge mclk) disable iff (!rstSyncN)
        (edgeHit && !s_q.ctrl[TCR_CTL_CAPTURE_RELOAD_SELECT] && !s_q.mode[TCR_MOD_DOWN_COUNT_ENABLE] && !doWr)
        |=> (s_q.cnt == $past(s_q.rcap)) && s_q.ctrl[TCR_CTL_EXTERNAL_EDGE_FLAG]) else $error("edge reload missed");
    a_rx_source: assert property (@(posedge mclk) disable iff (!rstSyncN)
        (serMode[0] && !s_q.ctrl[TCR_CTL_RX_BAUD_SEL]) |=> rxBaudTick == $past(timer1Ovf))
        else $error("receive baud source wrong");
    a_clock_out_hold: assert property (@(posedge mclk) disable iff (!rstSyncN)
        !s_q.mode[TCR_MOD_CLOCK_OUT_ENABLE] |=> $stable(clockOutO)) else $error("clock out moved");
    a_autoclear_pulse: assert property (@(posedge mclk) disable iff (!rstSyncN)
        (isrEnter[0] && s_q.mode[TCR_MOD_EXT_IRQ_AUTOCLEAR_LSB]) |=> extIrqClr[0]) else $error("irq clear missed");
endmodule : tcr_timer2
`default_nettype wire
